// File: inc/cbp_pkg.sv
// Constants, types and the CRC step for the configuration bitstream parser.
// Assumes a 100 MHz system clock; stream figures are for the largest member.
package cbp_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Parser states, Gray along the usual path
   typedef enum logic [3:0]
   {
      S_HUNT  = 4'h0,
      S_LEN   = 4'h1,
      S_SEP   = 4'h3,
      S_START = 4'h2,
      S_DATA  = 4'h6,
      S_CHECK = 4'h7,
      S_POST  = 4'h5,
      S_DONE  = 4'h4,
      S_ERR   = 4'hC
   } cbp_state_e;

   // Options strapped on pins
   typedef struct packed
   {
      logic master;
      logic express;
      logic crc_on;
      logic big;
   } cbp_opt_s;

   // One frame data item towards configuration memory
   typedef struct packed
   {
      logic       wide;
      logic [7:0] data;
   } cbp_word_s;

   ////////////////////////////////////////////////////////////////////////////
   // Stream codes
   localparam logic [7:0]  FILL          = 8'hFF;
   localparam logic [3:0]  PRE_SER       = 4'h2;
   localparam logic [7:0]  PRE_EXP       = 8'hF2;
   localparam logic [7:0]  START_EXP     = 8'hFE;
   localparam logic [7:0]  START_EXP_BIG = 8'hFF;
   localparam logic [3:0]  CHK_SER       = 4'h6;
   localparam logic [7:0]  CHK_EXP       = 8'hD2;
   localparam logic [7:0]  POST_SER      = 8'h7F;

   // Field lengths in config clocks
   localparam logic [15:0] LEN_W         = 16'h0018;
   localparam logic [15:0] LEN_BYTES     = 16'h0003;
   localparam logic [15:0] SEP_BITS      = 16'h0004;
   localparam logic [15:0] CHK_BITS      = 16'h0004;
   localparam logic [15:0] POST_BITS     = 16'h0008;
   localparam logic [15:0] TAIL_BITS     = 16'h0007;

   // Frame geometry: 307 bits less start bit and four check bits
   localparam logic [15:0] FRAME_DATA_BITS = 16'h012E;
   localparam logic [15:0] EXP_DATA_BYTES  = 16'h002B;
   localparam logic [10:0] FRAME_COUNT     = 11'h435;

   // CRC-16 CCITT
   localparam logic [15:0] CRC_POLY      = 16'h1021;
   localparam logic [15:0] CRC_INIT      = 16'h0000;

   // Master config clock, 1 MHz
   localparam int          CLK_NS        = 10;
   localparam int          CONFIG_CLOCK_HALF_NS  = 500;
   localparam logic [7:0]  CONFIG_CLOCK_HALF_CYC = 8'(CONFIG_CLOCK_HALF_NS / CLK_NS);

   localparam int          FIFO_DEPTH    = 16;

   function automatic logic [15:0] crc16_step(input logic [15:0] crc, input logic bit_in);
      logic fb;
      fb = crc[15] ^ bit_in;
      return {crc[14:0], 1'b0} ^ (fb ? CRC_POLY : CRC_INIT);
   endfunction

endpackage

// File: design/cbp_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module cbp_fifo
#(
   parameter int W = 9,
   parameter int D = 16
)
(
   input  wire logic         clk,
   input  wire logic         sys_rst,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(D);

   logic [W-1:0] mem_q [D];
   logic [AW:0]  wr_q;
   logic [AW:0]  rd_q;
   logic         push;
   logic         pop;

   assign in_ready  = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
   assign out_valid = wr_q != rd_q;
   assign out_data  = mem_q[rd_q[AW-1:0]];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem_q[wr_q[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         wr_q <= '0;
         rd_q <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop)
         begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end

endmodule // cbp_fifo

// File: design/cbp_parser.sv
// Configuration bitstream parser: header, frames, checks, postamble, readback CRC.
// Assumes config pins are asynchronous and sampled on clk; readback port is on clk.
//
// How it works
// - Serial header is eight ones, preamble, 24-bit count, then ones separator.
// - Preamble is 0010 serially, or byte 11110010 in express mode.
// - Express loading ignores the count and ends on memory full.
// - Each frame opens with a 0 bit, or byte FE (FF on big member).
// - Without CRC, the closing field must equal 0110 or D2, else error.
// - With CRC, four check bits per frame; last frame checks eleven bits.
// - Express mode only uses constant-field checking, never CRC.
// - Serial postamble 01111111 follows the last frame.
// - Start-up byte contents are ignored; they only provide clocks.
// - On error, loading stops before completion and init is pulled low.
// - As master, the config clock keeps running after an error.
// - Serial bits in stream order; express D0 is the leftmost bit.
// - Readback CRC-16 CCITT, eleven top bits appended.
// - Serial completion when clock count equals length count exactly.
// - Chained device in serial mode holds data output high while loading own frames.
// - Express mode takes one byte per rising config clock edge.
`timescale 1ns/10ps
module cbp_parser
#(
   parameter logic [15:0] P_DATA_BITS = cbp_pkg::FRAME_DATA_BITS,
   parameter logic [15:0] P_EXP_BYTES = cbp_pkg::EXP_DATA_BYTES,
   parameter logic [10:0] P_FRAMES    = cbp_pkg::FRAME_COUNT
)
(
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire logic              config_clock,
   input  wire logic              ser_data_in,
   input  wire logic [7:0]        byte_config_in,
   input  wire logic              program_n,
   input  wire cbp_pkg::cbp_opt_s opt_pins,
   output logic                   config_clock_o,
   output logic                   data_out,
   output logic                   done_o,
   output logic                   init_n_o,
   output logic                   init_n_oe,
   output logic                   error_o,
   output logic                   mem_valid,
   input  wire logic              mem_ready,
   output cbp_pkg::cbp_word_s     mem_word,
   input  wire logic              rb_bit,
   input  wire logic              rb_valid,
   input  wire logic              rb_clear,
   output logic [10:0]            rb_sum
);
   import cbp_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic        config_clock_s1_q, config_clock_s2_q, config_clock_s3_q;
   logic        din_s1_q, din_s2_q;
   logic [7:0]  byte_s1_q, byte_s2_q;
   logic        prog_s1_q, prog_s2_q;
   cbp_opt_s    opt_s1_q, opt_s2_q;

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         config_clock_s1_q <= 1'b0;
         config_clock_s2_q <= 1'b0;
         config_clock_s3_q <= 1'b0;
         din_s1_q  <= 1'b1;
         din_s2_q  <= 1'b1;
         byte_s1_q <= 8'hFF;
         byte_s2_q <= 8'hFF;
         prog_s1_q <= 1'b1;
         prog_s2_q <= 1'b1;
         opt_s1_q  <= '0;
         opt_s2_q  <= '0;
      end
      else
      begin
         config_clock_s1_q <= config_clock;
         config_clock_s2_q <= config_clock_s1_q;
         config_clock_s3_q <= config_clock_s2_q;
         din_s1_q  <= ser_data_in;
         din_s2_q  <= din_s1_q;
         byte_s1_q <= byte_config_in;
         byte_s2_q <= byte_s1_q;
         prog_s1_q <= program_n;
         prog_s2_q <= prog_s1_q;
         opt_s1_q  <= opt_pins;
         opt_s2_q  <= opt_s1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sampled stream
   logic        restart;
   logic        ev;
   logic        sb;
   logic [7:0]  eb;
   logic        xp;
   logic        crc_on;
   logic [7:0]  st_byte;

   assign restart = sys_rst || !prog_s2_q;
   assign ev      = config_clock_s2_q && !config_clock_s3_q;
   assign sb      = din_s2_q;
   assign eb      = {<<{byte_s2_q}};
   assign xp      = opt_s2_q.express;
   assign crc_on  = opt_s2_q.crc_on && !xp;
   assign st_byte = opt_s2_q.big ? START_EXP_BIG : START_EXP;

   cbp_state_e  state_q;
   logic [15:0] cnt_q;
   logic [10:0] frame_q;
   logic [3:0]  chk_q;
   logic [15:0] hist_q;
   logic [23:0] len_q;
   logic [23:0] clk_cnt_q;
   logic [15:0] crc_q;
   logic        err_q;
   logic        last_frame;
   logic        tail;
   logic        push;
   logic        f_ready;
   logic        bad;
   logic        pre_hit;
   logic [15:0] dlim;

   assign last_frame = frame_q == P_FRAMES - 11'h001;
   assign dlim       = xp ? P_EXP_BYTES : P_DATA_BITS;
   assign tail       = crc_on && last_frame && state_q == S_DATA && cnt_q >= P_DATA_BITS - TAIL_BITS;
   assign push       = ev && state_q == S_DATA;
   assign pre_hit    = xp ? {hist_q[7:0], eb} == {FILL, PRE_EXP}
                          : {hist_q[10:0], sb} == {FILL, PRE_SER};

   ////////////////////////////////////////////////////////////////////////////
   // Field checking
   always_comb
   begin
      bad = 1'b0;
      if (ev)
      begin
         unique case (state_q)
            S_SEP:   bad = xp ? eb != CHK_EXP : !sb;
            S_START: bad = xp && eb != st_byte;
            S_DATA:  bad = !f_ready || (tail && sb != crc_q[4'hF - chk_q]);
            S_CHECK:
            begin
               if (xp)
                  bad = eb != CHK_EXP;
               else if (crc_on)
                  bad = sb != crc_q[4'hF - chk_q];
               else
                  bad = sb != CHK_SER[2'h3 - cnt_q[1:0]];
            end
            S_POST:  bad = !(cnt_q == 16'h0000 && sb) && sb != POST_SER[3'h7 - cnt_q[2:0]];
            default: bad = 1'b0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Parser sequence
   always_ff @(posedge clk)
   begin
      if (restart)
      begin
         state_q <= S_HUNT;
         cnt_q   <= '0;
         frame_q <= '0;
         chk_q   <= '0;
         hist_q  <= '0;
         len_q   <= '0;
      end
      else if (ev)
      begin
         hist_q <= xp ? {hist_q[7:0], eb} : {hist_q[14:0], sb};
         if (bad)
         begin
            state_q <= S_ERR;
         end
         else
         begin
            unique case (state_q)
               // Leading extra ones just stay in the hunt
               S_HUNT:
               begin
                  if (pre_hit)
                  begin
                     state_q <= S_LEN;
                     cnt_q   <= '0;
                  end
               end
               S_LEN:
               begin
                  if (!xp)
                  begin
                     len_q <= {len_q[22:0], sb};
                  end
                  cnt_q <= cnt_q + 16'h0001;
                  if (cnt_q == (xp ? LEN_BYTES : LEN_W) - 16'h0001)
                  begin
                     state_q <= S_SEP;
                     cnt_q   <= '0;
                  end
               end
               S_SEP:
               begin
                  cnt_q <= cnt_q + 16'h0001;
                  if (xp || cnt_q == SEP_BITS - 16'h0001)
                  begin
                     state_q <= S_START;
                     cnt_q   <= '0;
                  end
               end
               // Ones after a frame's check bits are dummies
               S_START:
               begin
                  if (xp || !sb)
                  begin
                     state_q <= S_DATA;
                     cnt_q   <= '0;
                     chk_q   <= '0;
                  end
               end
               S_DATA:
               begin
                  cnt_q <= cnt_q + 16'h0001;
                  if (tail)
                  begin
                     chk_q <= chk_q + 4'h1;
                  end
                  if (cnt_q == dlim - 16'h0001)
                  begin
                     state_q <= S_CHECK;
                     cnt_q   <= '0;
                  end
               end
               S_CHECK:
               begin
                  chk_q <= chk_q + 4'h1;
                  cnt_q <= cnt_q + 16'h0001;
                  if (xp || cnt_q == CHK_BITS - 16'h0001)
                  begin
                     cnt_q   <= '0;
                     frame_q <= frame_q + 11'h001;
                     if (last_frame)
                        state_q <= xp ? S_DONE : S_POST;
                     else
                        state_q <= S_START;
                  end
               end
               S_POST:
               begin
                  if (!(cnt_q == 16'h0000 && sb))
                  begin
                     cnt_q <= cnt_q + 16'h0001;
                     if (cnt_q == POST_BITS - 16'h0001)
                     begin
                        state_q <= S_DONE;
                     end
                  end
               end
               S_DONE: state_q <= S_DONE;
               S_ERR:  state_q <= S_ERR;
               default: state_q <= S_ERR;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Running CRC over frame data, frozen across check bits
   always_ff @(posedge clk)
   begin
      if (restart)
         crc_q <= CRC_INIT;
      else if (push && crc_on && !tail)
         crc_q <= crc16_step(crc_q, sb);
   end

   // Counts every config clock from restart until an error, header and dummies included
   always_ff @(posedge clk)
   begin
      if (restart)
         clk_cnt_q <= '0;
      else if (ev && state_q != S_ERR)
         clk_cnt_q <= clk_cnt_q + 24'h000001;
   end

   always_ff @(posedge clk)
   begin
      if (restart)
         done_o <= 1'b0;
      else if (state_q == S_DONE && (xp || clk_cnt_q == len_q))
         done_o <= 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Chain output: serial passes header and overflow, express is a status
   always_ff @(posedge clk)
   begin
      if (restart)
         data_out <= 1'b1;
      else if (xp)
         data_out <= state_q inside {S_HUNT, S_LEN, S_DONE};
      else if (ev)
         data_out <= state_q inside {S_HUNT, S_LEN, S_POST, S_DONE} ? sb : 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (restart)
         err_q <= 1'b0;
      else if (bad)
         err_q <= 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         init_n_oe <= 1'b0;
         init_n_o  <= 1'b0;
         error_o   <= 1'b0;
      end
      else
      begin
         init_n_oe <= err_q || !prog_s2_q;
         init_n_o  <= 1'b0;
         error_o   <= err_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Master clock divider; error state does not stop it
   logic [7:0] div_q;

   always_ff @(posedge clk)
   begin
      if (sys_rst || !opt_s2_q.master)
      begin
         div_q          <= '0;
         config_clock_o <= 1'b0;
      end
      else if (div_q == CONFIG_CLOCK_HALF_CYC - 8'h01)
      begin
         div_q          <= '0;
         config_clock_o <= !config_clock_o;
      end
      else
      begin
         div_q <= div_q + 8'h01;
      end
   end

   // Config clock cannot stall, so a full buffer is a load error
   cbp_fifo #(.W($bits(cbp_word_s)), .D(FIFO_DEPTH)) u_fifo
   (
      .clk       (clk),
      .sys_rst   (restart),
      .in_valid  (push),
      .in_ready  (f_ready),
      .in_data   ({xp, xp ? eb : {7'h00, sb}}),
      .out_valid (mem_valid),
      .out_ready (mem_ready),
      .out_data  (mem_word)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Readback checksum
   logic [15:0] rb_crc_q;

   always_ff @(posedge clk)
   begin
      if (sys_rst || rb_clear)
         rb_crc_q <= CRC_INIT;
      else if (rb_valid)
         rb_crc_q <= crc16_step(rb_crc_q, rb_bit);
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         rb_sum <= '0;
      else
         rb_sum <= rb_crc_q[15:5];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence s_ser_chk_bad;
      prog_s2_q && ev && !xp && !crc_on && state_q == S_CHECK && sb != CHK_SER[2'h3 - cnt_q[1:0]];
   endsequence
   sequence s_exp_chk_bad;
      prog_s2_q && ev && xp && state_q == S_CHECK && eb != CHK_EXP;
   endsequence

   property p_ser_chk;
      s_ser_chk_bad |=> state_q == S_ERR ##1 init_n_oe;
   endproperty
   a_ser_chk: assert property (p_ser_chk) else $error("serial check mismatch not flagged");

   property p_exp_chk;
      s_exp_chk_bad |=> state_q == S_ERR && err_q;
   endproperty
   a_exp_chk: assert property (p_exp_chk) else $error("express check mismatch not flagged");

   property p_preamble;
      prog_s2_q && state_q == S_HUNT ##1 state_q == S_LEN |-> $past(pre_hit);
   endproperty
   a_preamble: assert property (p_preamble) else $error("length entered without preamble");

   property p_err_hold;
      err_q && prog_s2_q |=> err_q && !done_o;
   endproperty
   a_err_hold: assert property (p_err_hold) else $error("error flag dropped");

   property p_init_low;
      $rose(err_q) |=> init_n_oe [*3];
   endproperty
   a_init_low: assert property (p_init_low) else $error("init not pulled low");

   property p_master_clk;
      opt_s2_q.master && opt_s1_q.master |-> ##[1:51] $changed(config_clock_o);
   endproperty
   a_master_clk: assert property (p_master_clk) else $error("master clock stopped");

   property p_hold_high;
      prog_s2_q && !xp && state_q == S_DATA && ev |=> data_out;
   endproperty
   a_hold_high: assert property (p_hold_high) else $error("chain output not high");

   property p_len_match;
      prog_s2_q && !xp && $rose(done_o) |-> $past(clk_cnt_q) == $past(len_q);
   endproperty
   a_len_match: assert property (p_len_match) else $error("done without count match");

   property p_rb_sum;
      rb_valid && !rb_clear |=> ##1 rb_sum == $past(rb_crc_q[15:5]);
   endproperty
   a_rb_sum: assert property (p_rb_sum) else $error("readback sum stale");

endmodule // cbp_parser

// File: verification/cbp_src.sv
// Stream source model: link clock, serial bit and byte lanes.
// Assumes clk is the bench clock; link edges follow its falling edge.
`timescale 1ns/10ps
module cbp_src
(
   input  wire logic clk,
   output logic      config_clock,
   output logic      ser_data_in,
   output logic [7:0] byte_config_in
);
   initial
   begin
      config_clock = 1'b0;
      ser_data_in = 1'b1;
      byte_config_in = 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////
   // One 160 ns link cycle; the clock rests low between frames
   task automatic tick();
      repeat (8) @(negedge clk);
      config_clock = 1'b1;
      repeat (8) @(negedge clk);
      config_clock = 1'b0;
   endtask

   // Stream order, leftmost bit first
   task automatic send_bits(input logic [31:0] v, input int n);
      @(negedge clk); // Keeps the lane from being driven twice in one step
      for (int i = n - 1; i >= 0; i--)
      begin
         ser_data_in = v[i];
         tick();
      end
      ser_data_in = ~ser_data_in; // Released lane shows no stale bit
   endtask

   // D0 carries the leftmost stream bit
   task automatic send_byte(input logic [7:0] b);
      @(negedge clk);
      byte_config_in = {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]};
      tick();
      byte_config_in = ~byte_config_in;
   endtask
endmodule // cbp_src

// File: verification/tb_top.sv
// Self-checking bench for the bitstream parser.
// Assumes the source model in cbp_src and small frame parameters.
`timescale 1ns/10ps
module tb_top;
   import cbp_pkg::*;
   localparam logic [23:0] LEN = 24'h00004C;
   logic clk, sys_rst, program_n, mem_ready, rb_bit, rb_valid, rb_clear;
   logic config_clock, ser_data_in, config_clock_o, data_out, done_o;
   logic init_n_o, init_n_oe, error_o, mem_valid;
   logic [7:0] byte_config_in;
   logic [10:0] rb_sum;
   cbp_opt_s opt;
   cbp_word_s mem_word;
   cbp_word_s got[$];
   int num_errors = 0;
   int checks_done = 0;

   cbp_src src (.clk(clk), .config_clock(config_clock), .ser_data_in(ser_data_in),
      .byte_config_in(byte_config_in));

   cbp_parser #(.P_DATA_BITS(16'h0008), .P_EXP_BYTES(16'h0002), .P_FRAMES(11'h002)) dut
   (
      .clk(clk), .sys_rst(sys_rst), .config_clock(config_clock), .ser_data_in(ser_data_in),
      .byte_config_in(byte_config_in), .program_n(program_n), .opt_pins(opt),
      .config_clock_o(config_clock_o), .data_out(data_out), .done_o(done_o),
      .init_n_o(init_n_o), .init_n_oe(init_n_oe), .error_o(error_o), .mem_valid(mem_valid),
      .mem_ready(mem_ready), .mem_word(mem_word), .rb_bit(rb_bit), .rb_valid(rb_valid),
      .rb_clear(rb_clear), .rb_sum(rb_sum)
   );

   initial clk = 1'b0;
   always #5 clk = ~clk;

   always @(posedge clk)
      if (mem_valid === 1'b1 && mem_ready === 1'b1)
         got.push_back(mem_word);

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic restart(input logic [3:0] o);
      @(negedge clk);
      opt = o;
      mem_ready = 1'b0;
      program_n = 1'b0;
      repeat (4) @(negedge clk);
      program_n = 1'b1;
      repeat (6) @(negedge clk);
      got.delete();
   endtask

   // Two dummy ones lead the header, so the count holds them too
   task automatic ser_head();
      src.send_bits(32'h000003FF, 10);
      src.send_bits(32'h00000002, 4);
      src.send_bits({8'h00, LEN}, 24);
      src.send_bits(32'h0000000F, 4);
   endtask

   task automatic ser_frame(input logic [7:0] d, input logic [3:0] k);
      src.send_bits(32'h00000000, 1);
      src.send_bits({24'h000000, d}, 8);
      src.send_bits({28'h0000000, k}, 4);
   endtask

   task automatic t_serial();
      logic [7:0] d [2] = '{8'hA5, 8'h3C};
      restart(4'h0);
      ser_head();
      ser_frame(d[0], 4'h6);
      ser_frame(d[1], 4'h6);
      src.send_bits(32'h0000003F, 7);
      repeat (6) @(negedge clk);
      check(done_o, 1'b0);
      src.send_bits(32'h00000001, 1);
      repeat (6) @(negedge clk);
      check(done_o, 1'b1);
      src.send_bits(32'h0000005A, 8); // Odd start-up values
      check(error_o, 1'b0);
      check(done_o, 1'b1);
      mem_ready = 1'b1; // Sixteen words waited with the sink stalled
      repeat (30) @(negedge clk);
      check(got.size(), 16);
      for (int i = 0; i < 16; i++)
         check(got[i], {1'b0, 7'h00, d[i / 8][7 - i % 8]});
      check(mem_valid, 1'b0);
      $display("serial load test over");
   endtask

   task automatic t_express();
      logic [7:0] s [16] = '{8'hFF, 8'hF2, 8'h12, 8'h34, 8'h56, 8'hD2, 8'hFE, 8'h11,
         8'h22, 8'hD2, 8'hFE, 8'h33, 8'h44, 8'hD2, 8'hFF, 8'hFF};
      restart(4'h6); // CRC strap set but has no effect here
      for (int i = 0; i < 14; i++)
      begin
         src.send_byte(s[i]); // Count bytes are junk
         if (i == 8)
            check(data_out, 1'b0);
      end
      repeat (6) @(negedge clk);
      check(done_o, 1'b1);
      check(error_o, 1'b0);
      check(data_out, 1'b1);
      mem_ready = 1'b1;
      repeat (10) @(negedge clk);
      check(got.size(), 4);
      for (int i = 0; i < 4; i++)
         check(got[i], {1'b1, s[7 + i / 2 * 4 + i % 2]});
      $display("express load test over");
   endtask

   task automatic t_error();
      int n = 0;
      logic prev;
      restart(4'h0);
      mem_ready = 1'b1;
      ser_head();
      ser_frame(8'h0F, 4'h6);
      ser_frame(8'hF0, 4'h7);
      src.send_bits(32'h0000007F, 8);
      repeat (6) @(negedge clk);
      check(error_o, 1'b1);
      check(init_n_oe, 1'b1);
      check(done_o, 1'b0);
      check(init_n_o, 1'b0);
      opt.master = 1'b1;
      repeat (20) @(negedge clk);
      prev = config_clock_o;
      for (int i = 0; i < 200; i++)
      begin
         @(negedge clk);
         if (config_clock_o !== prev)
            n++;
         prev = config_clock_o;
      end
      check(n, 4);
      check(error_o, 1'b1);
      program_n = 1'b0;
      repeat (4) @(negedge clk);
      check(init_n_oe, 1'b1);
      program_n = 1'b1;
      repeat (6) @(negedge clk);
      check(error_o, 1'b0);
      check(init_n_oe, 1'b0);
      $display("frame error test over");
   endtask

   task automatic t_readback();
      logic [15:0] c = 16'h0000;
      logic [15:0] v = 16'hB38E;
      rb_clear = 1'b1;
      @(negedge clk);
      rb_clear = 1'b0;
      rb_valid = 1'b1;
      for (int i = 15; i >= 0; i--)
      begin
         rb_bit = v[i];
         c = {c[14:0], 1'b0} ^ ((c[15] ^ v[i]) ? CRC_POLY : 16'h0000);
         @(negedge clk);
      end
      rb_valid = 1'b0;
      repeat (4) @(negedge clk);
      check(rb_sum, c[15:5]);
      $display("readback test over");
   endtask

   // Big member start byte; second frame closes with a corrupt check byte
   task automatic t_exp_err();
      logic [7:0] s [14] = '{8'hFF, 8'hF2, 8'h00, 8'h00, 8'h00, 8'hD2, 8'hFF, 8'h11,
         8'h22, 8'hD2, 8'hFF, 8'h33, 8'h44, 8'hD3};
      restart(4'h5);
      for (int i = 0; i < 14; i++)
         src.send_byte(s[i]);
      repeat (6) @(negedge clk);
      check(error_o, 1'b1);
      check(done_o, 1'b0);
      check(data_out, 1'b0);
      mem_ready = 1'b1;
      repeat (10) @(negedge clk);
      check(got.size(), 4);
      $display("express error test over");
   endtask

   // Running CRC over data bits only; last frame closes with eleven bits
   task automatic t_crc();
      logic [15:0] c = 16'h0000;
      logic [7:0] d = 8'h96;
      restart(4'h2);
      ser_head();
      for (int i = 7; i >= 0; i--)
         c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? CRC_POLY : 16'h0000);
      ser_frame(d, c[15:12]);
      c = {c[14:0], 1'b0} ^ (c[15] ? CRC_POLY : 16'h0000);
      ser_frame({1'b0, c[15:9]}, c[8:5]);
      src.send_bits(32'h0000007F, 8);
      src.send_bits(32'h000000FF, 8);
      check(error_o, 1'b0);
      check(done_o, 1'b1);
      $display("crc load test over");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      sys_rst = 1'b1;
      program_n = 1'b1;
      opt = '0;
      mem_ready = 1'b0;
      rb_bit = 1'b0;
      rb_valid = 1'b0;
      rb_clear = 1'b0;
      repeat (6) @(negedge clk);
      sys_rst = 1'b0;
      t_readback();
      t_serial();
      t_express();
      t_exp_err();
      t_crc();
      t_error();
      report_and_stop();
   end

   // Whole run needs well under 100 us
   initial
   begin
      #300000;
      num_errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      report_and_stop();
   end
endmodule // tb_top
